// >>> rtl/gcsr_params.svh
// Purpose: Constants of the gauge command and status register bank
// Assumes: 20 MHz system clock
// Notes:   Included by bare name from every design file
`ifndef GCSR_PARAMS_SVH
`define GCSR_PARAMS_SVH

`define GCSR_ADDR_STATUS     7'h01
`define GCSR_ADDR_TEMPGG     7'h02
`define GCSR_CMD_WRITE_BIT   7
`define GCSR_READ_UNMAPPED   8'h00
`define GCSR_CPI_STALE       8'h40
`define GCSR_CPI_MAX         8'hFF
`define GCSR_SDC_LIMIT       16'h1000
`define GCSR_CHG_CLEAR       9'h100
`define GCSR_PACK_RST        1'b1
`define GCSR_STALE_RST       1'b1
`define GCSR_TEMP_LOW_C      -30
`define GCSR_TEMP_BAND_C     10
`define GCSR_TEMP_CODE_MAX   4'hC
`define GCSR_COLD_ENTER_C    0
`define GCSR_COLD_HYST_C     4
`define GCSR_DEEP_COLD_C     -20
`define GCSR_CLK_HZ          20000000
`define GCSR_BLINK_HZ        4
`define GCSR_BLINK_CYCLES    (`GCSR_CLK_HZ / (2 * `GCSR_BLINK_HZ))

`endif

// >>> rtl/gcsr_pkg.sv
// Purpose: Types shared by the gauge command and status register bank
// Assumes: gcsr_params.svh holds the numeric constants
// Notes:   Flag struct layout equals the status register bit layout
`include "gcsr_params.svh"
package gcsr_pkg;

    typedef enum logic [0:0] {
        GCSR_CMD   = 1'b0,
        GCSR_WDATA = 1'b1
    } gcsr_cmd_e;

    typedef struct packed {
        logic charging_flag;
        logic pack_replaced_flag;
        logic cell_overvoltage_flag;
        logic stale_capacity_flag;
        logic qualified_discharge_flag;
        logic unused2;
        logic empty_warning_flag;
        logic unused0;
    } gcsr_flags_s;

    typedef struct packed {
        logic offset_sense_below_chg;
        logic discharge_active;
        logic battery_sense_rise_0v1;
        logic reg_corrupt;
        logic battery_sense_above_2v0;
        logic battery_sense_below_0v90;
        logic current_sense_above_disable;
        logic valid_charge;
        logic capacity_update;
        logic charge_count_inc;
    } gcsr_sense_s;

    function automatic logic [3:0] gcsr_temp_code(input logic signed [7:0] temp_c);
        logic signed [8:0] span;
        // Nine bits so hot readings cannot wrap to a negative span
        span = 9'(temp_c) - 9'(`GCSR_TEMP_LOW_C);
        if (temp_c < 8'(`GCSR_TEMP_LOW_C)) begin
            return 4'h0;
        end else if (span >= 9'(11 * `GCSR_TEMP_BAND_C)) begin
            return `GCSR_TEMP_CODE_MAX;
        end else begin
            return 4'(span / 9'(`GCSR_TEMP_BAND_C)) + 4'h1;
        end
    endfunction

endpackage

// >>> rtl/gcsr_blink.sv
// Purpose: Square wave for the empty warning segment blink
// Assumes: Toggle count derived from the system clock rate
// Notes:   Phase restarts low whenever blinking is off
`timescale 1ns/100ps
`default_nettype none
`include "gcsr_params.svh"
module gcsr_blink
    import gcsr_pkg::*;
#(
    parameter int unsigned TOGGLE_CYCLES = `GCSR_BLINK_CYCLES
) (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic enable,
    output var  logic phase
);
    logic [23:0] count;

    always_ff @(posedge clk_sys) begin
        if (rst || !enable) begin
            count <= 24'h000000;
            phase <= 1'b0;
        end else if (count == 24'(TOGGLE_CYCLES - 1)) begin
            count <= 24'h000000;
            phase <= ~phase;
        end else begin
            count <= count + 24'h000001;
        end
    end
endmodule
`default_nettype wire

// >>> rtl/gcsr_gauge.sv
// Purpose: Cold corrected gauge fraction in sixteenths of the full reference
// Assumes: Charge and reference are whole counts, temperature in degrees C
// Notes:   Divider is combinational; the result is registered once
`timescale 1ns/100ps
`default_nettype none
`include "gcsr_params.svh"
module gcsr_gauge
    import gcsr_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire logic [7:0]        charge,
    input  wire logic [7:0]        full_ref,
    input  wire logic signed [7:0] temp_c,
    output var  logic              cold_band,
    output var  logic [3:0]        fraction
);
    logic [13:0] scaled;
    logic [13:0] quotient;
    logic        next_cold;

    always_comb begin
        next_cold = cold_band;
        if (!cold_band && temp_c < 8'(`GCSR_COLD_ENTER_C)) begin
            next_cold = 1'b1;
        end else if (cold_band && temp_c >= 8'(`GCSR_COLD_HYST_C)) begin
            next_cold = 1'b0;
        end
    end

    always_comb begin
        scaled = {2'b00, charge, 4'h0};
        if (temp_c < 8'(`GCSR_DEEP_COLD_C)) begin
            scaled = {3'b000, charge, 3'h0};
        end else if (cold_band) begin
            scaled = 14'(({2'b00, charge, 4'h0} * 14'h0003) >> 2);
        end
        quotient = (full_ref == 8'h00) ? 14'h0000 : scaled / {6'h00, full_ref};
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cold_band <= 1'b0;
            fraction  <= 4'h0;
        end else begin
            cold_band <= next_cold;
            fraction  <= (quotient > 14'h000F) ? 4'hF : quotient[3:0];
        end
    end
endmodule
`default_nettype wire

// >>> rtl/gcsr_regs.sv
// Function
// - Read command returns addressed register contents
// - Write command takes the following data byte
// - Seven-bit address; unwritable targets change nothing
// - Status register at 01h is read-only
// - Charging while sense below -400uV, no discharge
// - Pack replaced on corrupt rise or reset
// - Overvoltage follows sense above 2.0V, unlatched
// - Stale capacity on 64th charge, cleared by update
// - Qualified discharge set on discharge from full
// - Qualified discharge cleared past 4096 self-discharge
// - Qualified discharge cleared after 256 charge counts
// - Qualified discharge cleared by cold empty warning
// - Empty warning below 0.90V, latched until charge
// - Lowest segment blinks 4Hz during empty warning
// - Register 02h: temperature code over gauge fraction
// - Temperature code 0 to 12 in 10C bands
// - Gauge field in sixteenths, 0 to 15
// - Gauge from charge over chosen full reference
// - Gauge scaled 0.75 cold, 0.5 very cold
// - Cold band switching uses 4C hysteresis
// - Bytes arrive LSB first, at most 333 bit/s
// - Charge counter saturates at 255, cleared by update
//
// Purpose: Command decode and primary status flags of the charge monitor
// Assumes: A serial engine delivers whole bytes and sends answer bytes
// Notes:   Flags sample the sense inputs one clock after they change
`timescale 1ns/100ps
`default_nettype none
`include "gcsr_params.svh"
module gcsr_regs
    import gcsr_pkg::*;
#(
    parameter int unsigned BLINK_CYCLES = `GCSR_BLINK_CYCLES
) (
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire logic [7:0]        rx_byte,
    input  wire logic              rx_valid,
    input  wire gcsr_sense_s       sense,
    input  wire logic [15:0]       self_discharge_counter,
    input  wire logic [7:0]        remaining_charge_count,
    input  wire logic [7:0]        learned_full_capacity,
    input  wire logic [7:0]        programmed_full_capacity,
    input  wire logic              use_programmed_ref,
    input  wire logic signed [7:0] temp_c,
    output var  logic [7:0]        tx_byte,
    output var  logic              tx_valid,
    output var  gcsr_flags_s       flags,
    output var  logic [3:0]        temperature_code,
    output var  logic [3:0]        gauge_fraction,
    output var  logic [7:0]        charges_without_update_count,
    output var  logic              lowest_led_output
);
    gcsr_cmd_e   state;
    logic [8:0]  chg_counts;
    logic        discharge_d;
    logic        blink_phase;
    logic        cold_band;
    logic        full;
    logic        empty_set;
    logic        stale_set;
    logic        qual_clear;
    logic [7:0]  full_ref;
    logic [7:0]  read_data;
    logic [7:0]  next_chg;

    assign full      = remaining_charge_count == learned_full_capacity;
    assign full_ref  = use_programmed_ref ? programmed_full_capacity : learned_full_capacity;
    assign empty_set = sense.battery_sense_below_0v90 && !sense.current_sense_above_disable
                       && !flags.empty_warning_flag;
    assign next_chg  = sense.capacity_update ? 8'h00 : charges_without_update_count;
    assign stale_set = sense.valid_charge && (next_chg == 8'(`GCSR_CPI_STALE - 8'h01));

    // Read mux is priority ordered so a future register slots in easily
    always_comb begin
        if (rx_byte[6:0] == `GCSR_ADDR_STATUS) begin
            read_data = flags;
        end else if (rx_byte[6:0] == `GCSR_ADDR_TEMPGG) begin
            read_data = {temperature_code, gauge_fraction};
        end else begin
            read_data = `GCSR_READ_UNMAPPED;
        end
    end

    // Bytes are already assembled LSB first by the serial engine
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state    <= GCSR_CMD;
            tx_byte  <= 8'h00;
            tx_valid <= 1'b0;
        end else begin
            tx_valid <= 1'b0;
            case (state)
                GCSR_CMD: begin
                    if (rx_valid && rx_byte[`GCSR_CMD_WRITE_BIT]) begin
                        state <= GCSR_WDATA;
                    end else if (rx_valid) begin
                        tx_byte  <= read_data;
                        tx_valid <= 1'b1;
                    end
                end
                GCSR_WDATA: begin
                    // No writable register lives here, so the data byte is dropped
                    if (rx_valid) begin
                        state <= GCSR_CMD;
                    end
                end
                default: begin
                    state <= GCSR_CMD;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            flags.charging_flag         <= 1'b0;
            flags.cell_overvoltage_flag <= 1'b0;
            flags.unused2               <= 1'b0;
            flags.unused0               <= 1'b0;
        end else begin
            flags.charging_flag         <= sense.offset_sense_below_chg
                                           && !sense.discharge_active;
            flags.cell_overvoltage_flag <= sense.battery_sense_above_2v0;
            flags.unused2               <= 1'b0;
            flags.unused0               <= 1'b0;
        end
    end

    // Set terms are checked first so a coincident clear never loses an event
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            flags.pack_replaced_flag <= `GCSR_PACK_RST;
        end else if (sense.battery_sense_rise_0v1 && sense.reg_corrupt) begin
            flags.pack_replaced_flag <= 1'b1;
        end else if (full || empty_set) begin
            flags.pack_replaced_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            charges_without_update_count <= 8'h00;
        end else if (sense.valid_charge && next_chg != `GCSR_CPI_MAX) begin
            charges_without_update_count <= next_chg + 8'h01;
        end else begin
            charges_without_update_count <= next_chg;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            flags.stale_capacity_flag <= `GCSR_STALE_RST;
        end else if (stale_set) begin
            flags.stale_capacity_flag <= 1'b1;
        end else if (sense.capacity_update) begin
            flags.stale_capacity_flag <= 1'b0;
        end
    end

    assign qual_clear = sense.capacity_update
                     || (self_discharge_counter > `GCSR_SDC_LIMIT)
                     || (chg_counts >= `GCSR_CHG_CLEAR)
                     || (empty_set && temp_c < 8'(`GCSR_COLD_ENTER_C));

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            discharge_d <= 1'b0;
            chg_counts  <= 9'h000;
        end else begin
            discharge_d <= sense.discharge_active;
            if (!flags.qualified_discharge_flag) begin
                chg_counts <= 9'h000;
            end else if (sense.charge_count_inc && sense.offset_sense_below_chg
                         && chg_counts < `GCSR_CHG_CLEAR) begin
                chg_counts <= chg_counts + 9'h001;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            flags.qualified_discharge_flag <= 1'b0;
        end else if (sense.discharge_active && !discharge_d && full) begin
            flags.qualified_discharge_flag <= 1'b1;
        end else if (qual_clear) begin
            flags.qualified_discharge_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            flags.empty_warning_flag <= 1'b0;
        end else if (empty_set) begin
            flags.empty_warning_flag <= 1'b1;
        end else if (sense.valid_charge) begin
            flags.empty_warning_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            temperature_code  <= 4'h0;
            lowest_led_output <= 1'b0;
        end else begin
            temperature_code  <= gcsr_temp_code(temp_c);
            // Blink overrides the segment; the full display driver lives elsewhere
            lowest_led_output <= flags.empty_warning_flag ? blink_phase
                                 : (gauge_fraction != 4'h0);
        end
    end

    gcsr_gauge u_gauge (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .charge    (remaining_charge_count),
        .full_ref  (full_ref),
        .temp_c    (temp_c),
        .cold_band (cold_band),
        .fraction  (gauge_fraction)
    );

    gcsr_blink #(
        .TOGGLE_CYCLES (BLINK_CYCLES)
    ) u_blink (
        .clk_sys (clk_sys),
        .rst     (rst),
        .enable  (flags.empty_warning_flag),
        .phase   (blink_phase)
    );

    a_read_answer: assert property (@(posedge clk_sys) disable iff (rst)
        (state == GCSR_CMD && rx_valid && !rx_byte[7])
        |=> tx_valid && tx_byte == $past(read_data))
        else $error("read command not answered");

    a_write_silent: assert property (@(posedge clk_sys) disable iff (rst)
        (state == GCSR_CMD && rx_valid && rx_byte[7])
        |=> !tx_valid && state == GCSR_WDATA)
        else $error("write command answered or not awaiting data");

    a_write_no_effect: assert property (@(posedge clk_sys) disable iff (rst)
        (state == GCSR_WDATA && rx_valid) |=> !tx_valid && state == GCSR_CMD)
        else $error("write data byte misused");

    a_charging_follow: assert property (@(posedge clk_sys) disable iff (rst)
        sense.discharge_active |=> !flags.charging_flag)
        else $error("charging flag set during discharge");

    a_overvolt_follow: assert property (@(posedge clk_sys) disable iff (rst)
        ##1 flags.cell_overvoltage_flag == $past(sense.battery_sense_above_2v0))
        else $error("overvoltage flag does not follow sense");

    a_stale_set: assert property (@(posedge clk_sys) disable iff (rst)
        (charges_without_update_count == 8'h3F && sense.valid_charge
         && !sense.capacity_update)
        |=> flags.stale_capacity_flag && charges_without_update_count == 8'h40)
        else $error("stale flag missed on 64th charge");

    a_count_saturate: assert property (@(posedge clk_sys) disable iff (rst)
        (charges_without_update_count == 8'hFF && !sense.capacity_update)
        |=> charges_without_update_count == 8'hFF)
        else $error("charge counter wrapped");

    a_qual_sdc_clear: assert property (@(posedge clk_sys) disable iff (rst)
        (self_discharge_counter > 16'h1000 && !(sense.discharge_active && !discharge_d && full))
        |=> !flags.qualified_discharge_flag)
        else $error("qualified flag kept past self-discharge limit");

    a_empty_latched: assert property (@(posedge clk_sys) disable iff (rst)
        (flags.empty_warning_flag && !sense.valid_charge)
        |=> flags.empty_warning_flag)
        else $error("empty flag dropped without charge");

    a_unused_zero: assert property (@(posedge clk_sys) disable iff (rst)
        ##1 !flags.unused2 && !flags.unused0)
        else $error("unused status bits set");

    a_temp_code_max: assert property (@(posedge clk_sys) disable iff (rst)
        temperature_code <= 4'hC)
        else $error("temperature code above twelve");

    a_replace_clear: assert property (@(posedge clk_sys) disable iff (rst)
        (full && !(sense.battery_sense_rise_0v1 && sense.reg_corrupt))
        |=> !flags.pack_replaced_flag)
        else $error("pack replaced flag not cleared at full");

    a_pack_set: assert property (@(posedge clk_sys) disable iff (rst)
        (sense.battery_sense_rise_0v1 && sense.reg_corrupt) |=> flags.pack_replaced_flag)
        else $error("pack replaced flag not set");

    a_qual_set: assert property (@(posedge clk_sys) disable iff (rst)
        (sense.discharge_active && !discharge_d && full) |=> flags.qualified_discharge_flag)
        else $error("qualified flag not set on discharge from full");

    a_qual_chg_clear: assert property (@(posedge clk_sys) disable iff (rst)
        (chg_counts >= 9'h100 && !(sense.discharge_active && !discharge_d && full))
        |=> !flags.qualified_discharge_flag)
        else $error("qualified flag kept after charge");

    a_qual_cold_clear: assert property (@(posedge clk_sys) disable iff (rst)
        (empty_set && temp_c < 8'sh00 && !(sense.discharge_active && !discharge_d && full))
        |=> !flags.qualified_discharge_flag)
        else $error("qualified flag kept after cold empty warning");

    a_empty_set: assert property (@(posedge clk_sys) disable iff (rst)
        empty_set |=> flags.empty_warning_flag)
        else $error("empty flag not set");

    a_led_blink: assert property (@(posedge clk_sys) disable iff (rst)
        flags.empty_warning_flag |=> lowest_led_output == $past(blink_phase))
        else $error("lowest segment not blinking");

    a_tempgg_read: assert property (@(posedge clk_sys) disable iff (rst)
        (state == GCSR_CMD && rx_valid && rx_byte == 8'h02)
        |=> tx_byte == {$past(temperature_code), $past(gauge_fraction)})
        else $error("temperature and gauge answer wrong");

    a_count_clear: assert property (@(posedge clk_sys) disable iff (rst)
        (sense.capacity_update && !sense.valid_charge) |=> charges_without_update_count == 8'h00)
        else $error("charge counter not cleared by update");

    a_stale_clear: assert property (@(posedge clk_sys) disable iff (rst)
        (sense.capacity_update && !sense.valid_charge) |=> !flags.stale_capacity_flag)
        else $error("stale flag not cleared by update");

    a_count_step: assert property (@(posedge clk_sys) disable iff (rst)
        (charges_without_update_count != 8'hFF && sense.valid_charge && !sense.capacity_update)
        |=> charges_without_update_count == $past(charges_without_update_count) + 8'h01)
        else $error("charge counter did not step");

    c_read_status: cover property (@(posedge clk_sys) disable iff (rst)
        state == GCSR_CMD && rx_valid && rx_byte == 8'h01 ##1 tx_valid);
    c_write_cycle: cover property (@(posedge clk_sys) disable iff (rst)
        state == GCSR_CMD && rx_valid && rx_byte[7] ##[1:20] state == GCSR_WDATA && rx_valid);
    c_empty_blink: cover property (@(posedge clk_sys) disable iff (rst)
        flags.empty_warning_flag && lowest_led_output);
    c_qual_set: cover property (@(posedge clk_sys) disable iff (rst)
        $rose(flags.qualified_discharge_flag));
    c_stale_set: cover property (@(posedge clk_sys) disable iff (rst)
        $rose(flags.stale_capacity_flag));
endmodule
`default_nettype wire

// >>> tb/gcsr_host_model.sv
// Purpose: Host processor side of the command link, at whole-byte level
// Assumes: Serial engine assembles bytes; tx_valid stands one cycle
// Notes:   Drives on the falling edge; a released byte lane shows the inverse
`timescale 1ns/100ps
`default_nettype none
module gcsr_host_model (
    input  wire logic       clk_sys,
    input  wire logic [7:0] tx_byte,
    input  wire logic       tx_valid,
    output var  logic [7:0] rx_byte,
    output var  logic       rx_valid
);
    initial begin
        rx_byte  = 8'h00;
        rx_valid = 1'b0;
    end

    // Bit order and bit pacing belong to the serial engine, so bytes arrive whole
    task automatic send(input logic [7:0] b);
        @(negedge clk_sys);
        rx_byte  = b;
        rx_valid = 1'b1;
        @(negedge clk_sys);
        rx_valid = 1'b0;
        rx_byte  = ~b;
    endtask

    task automatic write_reg(input logic [6:0] a, input logic [7:0] d);
        send({1'b1, a});
        send(d);
    endtask

    // Unknown result if no answer comes, so a silent design cannot match
    task automatic read_reg(input logic [6:0] a, output logic [7:0] d);
        bit ok;
        ok = 1'b0;
        d  = 8'hXX;
        send({1'b0, a});
        for (int i = 0; i < 4 && !ok; i++) begin
            if (tx_valid === 1'b1) begin
                ok = 1'b1;
                d  = tx_byte;
            end else begin
                @(negedge clk_sys);
            end
        end
    endtask
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Purpose: Self-checking bench for the command and status register bank
// Assumes: Blink half period shortened to 4 cycles
// Notes:   Inputs change on the falling edge only
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import gcsr_pkg::*;
    localparam logic [9:0] M_VC   = 10'h004;
    localparam logic [9:0] M_CU   = 10'h002;
    localparam logic [9:0] M_INC  = 10'h001;
    localparam logic [9:0] M_RISE = 10'h080;

    logic              clk_sys = 1'b0;
    logic              rst     = 1'b1;
    gcsr_sense_s       sense   = '0;
    logic [15:0]       sd_cnt  = 16'h0000;
    logic [7:0]        remc    = 8'h64;
    logic [7:0]        learned = 8'hC8;
    logic [7:0]        prog    = 8'h64;
    logic              use_prg = 1'b0;
    logic signed [7:0] temp    = 8'sh19;
    logic [7:0]        rx_byte;
    logic              rx_valid;
    logic [7:0]        tx_byte;
    logic              tx_valid;
    gcsr_flags_s       flags;
    logic [3:0]        tcode;
    logic [3:0]        gauge;
    logic [7:0]        chg_cnt;
    logic              led;
    int                fails     = 0;
    int                cmp_count = 0;
    int                n;
    logic              prev;
    int                t_tab [12] = '{-40, -31, -30, -21, -1, 0, 9, 10, 79, 80, 90, 127};
    logic [3:0]        c_tab [12] = '{0, 0, 1, 1, 3, 4, 4, 5, 11, 12, 12, 12};

    always #25 clk_sys = ~clk_sys;

    gcsr_host_model i_host (
        .clk_sys  (clk_sys),
        .tx_byte  (tx_byte),
        .tx_valid (tx_valid),
        .rx_byte  (rx_byte),
        .rx_valid (rx_valid)
    );

    gcsr_regs #(.BLINK_CYCLES(4)) i_dut (
        .clk_sys                      (clk_sys),
        .rst                          (rst),
        .rx_byte                      (rx_byte),
        .rx_valid                     (rx_valid),
        .sense                        (sense),
        .self_discharge_counter       (sd_cnt),
        .remaining_charge_count       (remc),
        .learned_full_capacity        (learned),
        .programmed_full_capacity     (prog),
        .use_programmed_ref           (use_prg),
        .temp_c                       (temp),
        .tx_byte                      (tx_byte),
        .tx_valid                     (tx_valid),
        .flags                        (flags),
        .temperature_code             (tcode),
        .gauge_fraction               (gauge),
        .charges_without_update_count (chg_cnt),
        .lowest_led_output            (led)
    );

    task automatic step(input int k);
        repeat (k) @(negedge clk_sys);
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] d;
        i_host.read_reg(a, d);
        chk(d, exp);
    endtask

    // Trailing gap keeps back-to-back pulses from landing in one time step
    task automatic pulse(input logic [9:0] m);
        sense = gcsr_sense_s'(sense | m);
        step(1);
        sense = gcsr_sense_s'(sense & ~m);
        step(1);
    endtask

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        step(20000);
        fails++;
        summarize();
    end

    initial begin
        step(8);
        rst = 1'b0;
        step(2);
        chk(flags, 8'h50);
        rd(7'h01, 8'h50);
        rd(7'h7F, 8'h00);
        i_host.write_reg(7'h01, 8'hFF);
        i_host.write_reg(7'h7F, 8'hAA);
        rd(7'h01, 8'h50);
        $display("test access done");

        sense.offset_sense_below_chg  = 1'b1;
        sense.battery_sense_above_2v0 = 1'b1;
        step(2);
        rd(7'h01, 8'hF0);
        sense.discharge_active        = 1'b1;
        sense.battery_sense_above_2v0 = 1'b0;
        step(2);
        chk(flags, 8'h50);
        sense.discharge_active       = 1'b0;
        sense.offset_sense_below_chg = 1'b0;
        $display("test follow flags done");

        sense.battery_sense_below_0v90    = 1'b1;
        sense.current_sense_above_disable = 1'b1;
        step(3);
        chk(flags, 8'h50);
        sense.current_sense_above_disable = 1'b0;
        step(2);
        chk(flags, 8'h12);
        n    = 0;
        prev = led;
        repeat (16) begin
            step(1);
            if (led !== prev) n++;
            prev = led;
        end
        chk(8'(n), 8'h04);
        sense.battery_sense_below_0v90 = 1'b0;
        pulse(M_VC);
        step(1);
        chk(flags, 8'h10);
        $display("test empty done");

        pulse(M_CU);
        step(1);
        chk(flags, 8'h00);
        chk(chg_cnt, 8'h00);
        repeat (63) pulse(M_VC);
        step(1);
        chk(flags, 8'h00);
        pulse(M_VC);
        step(1);
        chk(flags, 8'h10);
        repeat (200) pulse(M_VC);
        step(1);
        chk(chg_cnt, 8'hFF);
        pulse(M_CU);
        step(1);
        chk(chg_cnt, 8'h00);
        chk(flags, 8'h00);
        $display("test count done");

        remc = 8'hC8;
        sense.discharge_active = 1'b1;
        step(2);
        chk(flags, 8'h08);
        sense.discharge_active = 1'b0;
        sd_cnt = 16'h1000;
        step(2);
        chk(flags, 8'h08);
        sd_cnt = 16'h1001;
        step(2);
        chk(flags, 8'h00);
        sd_cnt = 16'h0000;
        sense.discharge_active = 1'b1;
        step(2);
        sense.discharge_active       = 1'b0;
        sense.offset_sense_below_chg = 1'b1;
        repeat (255) pulse(M_INC);
        step(1);
        chk(flags, 8'h88);
        pulse(M_INC);
        step(1);
        chk(flags, 8'h80);
        sense.offset_sense_below_chg = 1'b0;
        sense.discharge_active       = 1'b1;
        step(2);
        sense.discharge_active = 1'b0;
        temp = -8'sh05;
        step(2);
        sense.battery_sense_below_0v90 = 1'b1;
        step(2);
        chk(flags, 8'h02);
        sense.battery_sense_below_0v90 = 1'b0;
        pulse(M_VC);
        $display("test qualified done");

        remc = 8'h64;
        sense.reg_corrupt = 1'b1;
        pulse(M_RISE);
        sense.reg_corrupt = 1'b0;
        step(1);
        chk(flags, 8'h40);
        foreach (t_tab[i]) begin
            temp = 8'(t_tab[i]);
            step(3);
            chk({4'h0, tcode}, {4'h0, c_tab[i]});
        end
        temp = 8'sh19;
        step(4);
        rd(7'h02, 8'h68);
        temp = -8'sh05;
        step(4);
        chk({4'h0, gauge}, 8'h06);
        temp = 8'sh02;
        step(4);
        chk({4'h0, gauge}, 8'h06);
        temp = 8'sh04;
        step(4);
        chk({4'h0, gauge}, 8'h08);
        temp = 8'sh00;
        step(4);
        chk({4'h0, gauge}, 8'h08);
        temp = -8'sh19;
        step(4);
        chk({4'h0, gauge}, 8'h04);
        temp = 8'sh19;
        remc = 8'hC8;
        step(4);
        chk({4'h0, gauge}, 8'h0F);
        use_prg = 1'b1;
        remc    = 8'h32;
        step(4);
        chk({3'h0, led, gauge}, 8'h18);
        remc = 8'h00;
        step(4);
        chk({3'h0, led, gauge}, 8'h00);
        $display("test temperature and gauge done");
        summarize();
    end
endmodule
`default_nettype wire
